/* hw/rcc_glitch_detect.sv */
// glitch detector that blocks the main crystal clock
`timescale 1ns/1ps

module rcc_glitch_detect (
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_level,
  input  wire logic i_clear,
  output logic      o_blocked
);

  typedef struct packed {
    logic                              prev;
    logic                              seen_edge;
    logic [rcc_pkg::GLITCH_CNT_W-1:0]  width;
    logic                              blocked;
  } rcc_glitch_state_type;

  rcc_glitch_state_type st_q;
  rcc_glitch_state_type st_d;

  always_comb begin
    st_d      = st_q;
    st_d.prev = i_level;
    if (i_level != st_q.prev) begin
      // a phase no wider than the threshold between two edges is a glitch
      if (st_q.seen_edge &&
          st_q.width <= rcc_pkg::GLITCH_CNT_W'(rcc_pkg::GLITCH_CYCLES)) begin
        st_d.blocked = 1'b1;  // see (RULE13)
      end
      st_d.seen_edge = 1'b1;
      st_d.width     = rcc_pkg::GLITCH_CNT_W'(1);
    end else if (st_q.width != '1) begin
      st_d.width = st_q.width + rcc_pkg::GLITCH_CNT_W'(1);
    end
    // only a chip reset lifts the block, so a faulty crystal stays cut off
    if (i_clear) begin
      st_d.blocked   = 1'b0;
      st_d.seen_edge = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_blocked = st_q.blocked;

endmodule : rcc_glitch_detect

/* hw/rcc_pkg.sv */
// constants shared by the reset and clock control block
package rcc_pkg;

  // ****************************************
  // register map (byte addresses on apb)
  // ****************************************
  localparam int          ADDR_W             = 12;
  localparam logic [11:0] ADDR_SW_RESET      = 12'h000;
  localparam logic [11:0] ADDR_CORE_CLK_CONF = 12'h004;
  localparam logic [11:0] ADDR_AON_CLK_CONF  = 12'h008;
  localparam logic [11:0] ADDR_STATUS        = 12'h00c;

  // ****************************************
  // reset levels, narrowest first
  // ****************************************
  localparam int NUM_LEVELS   = 5;
  localparam int LVL_FIRST    = 0;
  localparam int LVL_SECOND   = 1;
  localparam int LVL_CORE     = 2;
  localparam int LVL_SYSTEM   = 3;
  localparam int LVL_CHIP     = 4;
  localparam int RESET_HOLD_DEFAULT = 16;

  // ****************************************
  // clock inputs, index into the sampled vector
  // ****************************************
  localparam int NUM_CLOCKS     = 5;
  localparam int CLK_CRYSTAL    = 0;
  localparam int CLK_FAST_OSC   = 1;
  localparam int CLK_SLOW_OSC   = 2;
  localparam int CLK_LS_CRYSTAL = 3;
  localparam int CLK_PLL        = 4;

  // ****************************************
  // clock configuration fields
  // ****************************************
  typedef enum logic [1:0] {
    CORE_SRC_CRYSTAL  = 2'h0,
    CORE_SRC_FAST_OSC = 2'h1,
    CORE_SRC_PLL      = 2'h2
  } rcc_core_src_type;

  typedef enum logic [1:0] {
    SLOW_SRC_LS_CRYSTAL = 2'h0,
    SLOW_SRC_SLOW_OSC   = 2'h1,
    SLOW_SRC_FAST_DIV   = 2'h2
  } rcc_slow_src_type;

  localparam int         CORE_SRC_LSB   = 0;
  localparam int         CORE_DIV_LSB   = 4;
  localparam int         CORE_DIV_W     = 8;
  // divide factor is twice this value; zero passes the source straight through
  localparam logic [7:0] CORE_DIV_RESET = 8'h01;
  localparam int         SLOW_SRC_LSB   = 0;
  localparam int         FAST_SRC_BIT   = 4;
  localparam logic       FAST_SRC_RESET = 1'b0;
  localparam int         FAST_OSC_DIV   = 256;
  localparam int         DIV256_W       = 7;

  // ****************************************
  // status fields
  // ****************************************
  localparam int STAT_BLOCKED_BIT = 0;
  localparam int STAT_ACTIVE_LSB  = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLOCK_PERIOD_PS = 5000;
  localparam int GLITCH_WIDTH_PS = 3000;
  localparam int GLITCH_CYCLES   = (GLITCH_WIDTH_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int GLITCH_CNT_W    = 4;

endpackage : rcc_pkg

/* hw/rcc_top.sv */
// reset and clock control: nested reset levels, clock selection and apb registers
`timescale 1ns/1ps

// What this block does
// (RULE1) four reset levels: single core, digital core, system, whole chip.
// (RULE2) single-core reset hits only its own core; core restarts from reset vector.
// (RULE3) reset of the first core also resets the security-sensitive registers.
// (RULE4) digital-core reset hits cores, peripherals, basebands, pins; not always-on domain.
// (RULE5) system reset hits the whole digital system including always-on domain.
// (RULE6) chip reset hits every part of the chip.
// (RULE7) resets requested by software register writes or by hardware circuitry.
// (RULE8) core clock from crystal, fast oscillator or pll, direct or divided.
// (RULE9) after first core reset the core clock is crystal divided by 2.
// (RULE10) slow always-on clock: low-speed crystal, slow oscillator or fast oscillator/256.
// (RULE11) slow always-on clock drives counter, watchdog and low-power controller.
// (RULE12) fast always-on clock: crystal divided by 2 or fast oscillator.
// (RULE13) a crystal glitch under 3 ns blocks the crystal clock.
// (RULE14) each wider reset also asserts every narrower reset.
module rcc_top #(
  parameter int RESET_HOLD_CYCLES = rcc_pkg::RESET_HOLD_DEFAULT
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // apb slave
  input  wire logic [11:0] i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // hardware reset requests, asynchronous
  input  wire logic        i_hw_first_core_reset_req,
  input  wire logic        i_hw_second_core_reset_req,
  input  wire logic        i_hw_core_reset_req,
  input  wire logic        i_hw_system_reset_req,
  input  wire logic        i_hw_chip_reset_req,
  // clock sources, oversampled
  input  wire logic        i_main_crystal_clock,
  input  wire logic        i_fast_osc_clock,
  input  wire logic        i_slow_osc_clock,
  input  wire logic        i_low_speed_crystal_clock,
  input  wire logic        i_pll_clock,
  // reset outputs
  output logic             o_first_processor_core_reset_n,
  output logic             o_second_processor_core_reset_n,
  output logic             o_digital_core_reset_n,
  output logic             o_system_reset_n,
  output logic             o_chip_reset_n,
  output logic             o_always_on_reset_n,
  output logic             o_secure_reg_reset_n,
  // clock outputs
  output logic             o_core_clock,
  output logic             o_slow_aon_clock,
  output logic             o_fast_aon_clock,
  output logic             o_main_crystal_blocked
);

  localparam int CNT_W = $clog2(RESET_HOLD_CYCLES + 1);
  localparam int NL    = rcc_pkg::NUM_LEVELS;
  localparam int NC    = rcc_pkg::NUM_CLOCKS;
  localparam int DW    = rcc_pkg::CORE_DIV_W;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NL-1:0]                     hw_sync1;
    logic [NL-1:0]                     hw_sync2;
    logic [NC-1:0]                     clk_sync1;
    logic [NC-1:0]                     clk_sync2;
    logic [NC-1:0]                     clk_prev;
    logic [NL-1:0][CNT_W-1:0]          hold;
    logic [NL-1:0]                     rst_n;
    logic                              aon_rst_n;
    logic                              secure_rst_n;
    rcc_pkg::rcc_core_src_type         core_src;
    logic [DW-1:0]                     core_div;
    logic [DW-1:0]                     core_edges;
    logic                              core_clk;
    rcc_pkg::rcc_slow_src_type         slow_src;
    logic                              fast_src;
    logic [rcc_pkg::DIV256_W-1:0]      div256_cnt;
    logic                              fast_div256;
    logic                              xtal_div2;
    logic                              slow_clk;
    logic                              fast_clk;
    logic                              blocked;
    logic                              pready;
    logic                              pslverr;
    logic [31:0]                       prdata;
  } rcc_state_type;

  rcc_state_type st_q;
  rcc_state_type st_d;
  logic          glitch_blocked;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction : is_rise

  function automatic logic addr_is_mapped(input logic [11:0] addr);
    if (addr == rcc_pkg::ADDR_SW_RESET) begin
      return 1'b1;
    end else if (addr == rcc_pkg::ADDR_CORE_CLK_CONF) begin
      return 1'b1;
    end else if (addr == rcc_pkg::ADDR_AON_CLK_CONF) begin
      return 1'b1;
    end else if (addr == rcc_pkg::ADDR_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_is_mapped

  // ****************************************
  // crystal glitch watch
  // ****************************************
  rcc_glitch_detect u_glitch (
    .i_clock   (i_clock),
    .i_resetn  (i_resetn),
    .i_level   (st_q.clk_sync2[rcc_pkg::CLK_CRYSTAL]),
    .i_clear   (~st_q.rst_n[rcc_pkg::LVL_CHIP]),
    .o_blocked (glitch_blocked)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [NL-1:0] sw_req;
    logic [NL-1:0] req;
    logic [NL-1:0] eff;
    logic [NL-1:0] active;
    logic [NC-1:0] live;
    logic [NC-1:0] rise;
    logic          wr;
    logic          core_lvl;
    logic          core_rise;
    sw_req    = '0;
    req       = '0;
    eff       = '0;
    active    = '0;
    live      = '0;
    rise      = '0;
    core_lvl  = 1'b0;
    core_rise = 1'b0;
    wr        = 1'b0;
    st_d      = st_q;

    // two flip-flops on every reset request and clock source pin before use
    st_d.hw_sync1  = {i_hw_chip_reset_req, i_hw_system_reset_req, i_hw_core_reset_req,
                      i_hw_second_core_reset_req, i_hw_first_core_reset_req};
    st_d.hw_sync2  = st_q.hw_sync1;
    st_d.clk_sync1 = {i_pll_clock, i_low_speed_crystal_clock, i_slow_osc_clock,
                      i_fast_osc_clock, i_main_crystal_clock};
    st_d.clk_sync2 = st_q.clk_sync1;
    st_d.blocked   = glitch_blocked;

    live = st_q.clk_sync2;
    live[rcc_pkg::CLK_CRYSTAL] = st_q.clk_sync2[rcc_pkg::CLK_CRYSTAL] & ~st_q.blocked; // see (RULE13)
    st_d.clk_prev = live;
    for (int i = 0; i < NC; i++) begin
      rise[i] = is_rise(st_q.clk_prev[i], live[i]);
    end

    // apb: setup cycle latches the answer, access cycle presents it
    wr = i_psel & i_penable & st_q.pready & i_pwrite & addr_is_mapped(i_paddr);
    for (int i = 0; i < NL; i++) begin
      active[i] = (st_q.hold[i] != '0);
    end
    st_d.pready  = i_psel & ~i_penable;
    st_d.pslverr = i_psel & ~i_penable & ~addr_is_mapped(i_paddr);
    st_d.prdata  = '0;
    if (i_psel && !i_penable && !i_pwrite) begin
      if (i_paddr == rcc_pkg::ADDR_SW_RESET) begin
        st_d.prdata[NL-1:0] = active;
      end else if (i_paddr == rcc_pkg::ADDR_CORE_CLK_CONF) begin
        st_d.prdata[rcc_pkg::CORE_SRC_LSB +: 2] = st_q.core_src;
        st_d.prdata[rcc_pkg::CORE_DIV_LSB +: DW] = st_q.core_div;
      end else if (i_paddr == rcc_pkg::ADDR_AON_CLK_CONF) begin
        st_d.prdata[rcc_pkg::SLOW_SRC_LSB +: 2] = st_q.slow_src;
        st_d.prdata[rcc_pkg::FAST_SRC_BIT] = st_q.fast_src;
      end else if (i_paddr == rcc_pkg::ADDR_STATUS) begin
        st_d.prdata[rcc_pkg::STAT_BLOCKED_BIT] = st_q.blocked;
        st_d.prdata[rcc_pkg::STAT_ACTIVE_LSB +: NL] = active;
      end
    end

    // reset requests from software and from circuitry
    if (wr && i_paddr == rcc_pkg::ADDR_SW_RESET) begin
      sw_req = i_pwdata[NL-1:0]; // see (RULE7)
    end
    req = st_q.hw_sync2 | sw_req; // see (RULE7)

    // widen each request downward through the nesting
    eff[rcc_pkg::LVL_CHIP]   = req[rcc_pkg::LVL_CHIP];                            // see (RULE6)
    eff[rcc_pkg::LVL_SYSTEM] = req[rcc_pkg::LVL_SYSTEM] | eff[rcc_pkg::LVL_CHIP]; // see (RULE14)
    eff[rcc_pkg::LVL_CORE]   = req[rcc_pkg::LVL_CORE] | eff[rcc_pkg::LVL_SYSTEM]; // see (RULE14)
    eff[rcc_pkg::LVL_FIRST]  = req[rcc_pkg::LVL_FIRST] | eff[rcc_pkg::LVL_CORE];  // see (RULE2)
    eff[rcc_pkg::LVL_SECOND] = req[rcc_pkg::LVL_SECOND] | eff[rcc_pkg::LVL_CORE]; // see (RULE2)

    // every level holds for the same time after its last request
    for (int i = 0; i < NL; i++) begin
      if (eff[i]) begin
        st_d.hold[i] = CNT_W'(RESET_HOLD_CYCLES); // see (RULE1)
      end else if (active[i]) begin
        st_d.hold[i] = st_q.hold[i] - CNT_W'(1);
      end
      st_d.rst_n[i] = ~active[i]; // see (RULE4)
    end
    // always-on domain escapes the digital-core reset
    st_d.aon_rst_n    = ~active[rcc_pkg::LVL_SYSTEM]; // see (RULE5)
    st_d.secure_rst_n = ~active[rcc_pkg::LVL_FIRST];  // see (RULE3)

    // ****************************************
    // core clock
    // ****************************************
    if (active[rcc_pkg::LVL_FIRST]) begin
      st_d.core_src   = rcc_pkg::CORE_SRC_CRYSTAL; // see (RULE9)
      st_d.core_div   = rcc_pkg::CORE_DIV_RESET;   // see (RULE9)
      st_d.core_edges = '0;
    end else if (wr && i_paddr == rcc_pkg::ADDR_CORE_CLK_CONF) begin
      // code 3 names no source, so the old selection is kept
      if (i_pwdata[rcc_pkg::CORE_SRC_LSB +: 2] != 2'h3) begin
        st_d.core_src = rcc_pkg::rcc_core_src_type'(i_pwdata[rcc_pkg::CORE_SRC_LSB +: 2]);
      end
      st_d.core_div   = i_pwdata[rcc_pkg::CORE_DIV_LSB +: DW];
      st_d.core_edges = '0;
    end
    case (st_q.core_src)
      rcc_pkg::CORE_SRC_FAST_OSC: begin
        core_lvl  = live[rcc_pkg::CLK_FAST_OSC];
        core_rise = rise[rcc_pkg::CLK_FAST_OSC];
      end
      rcc_pkg::CORE_SRC_PLL: begin
        core_lvl  = live[rcc_pkg::CLK_PLL];
        core_rise = rise[rcc_pkg::CLK_PLL];
      end
      default: begin
        core_lvl  = live[rcc_pkg::CLK_CRYSTAL];
        core_rise = rise[rcc_pkg::CLK_CRYSTAL];
      end
    endcase
    if (st_q.core_div == '0) begin
      st_d.core_clk = core_lvl; // see (RULE8)
    end else if (core_rise) begin
      if (st_q.core_edges + DW'(1) >= st_q.core_div) begin
        st_d.core_clk   = ~st_q.core_clk; // see (RULE8)
        st_d.core_edges = '0;
      end else begin
        st_d.core_edges = st_q.core_edges + DW'(1);
      end
    end

    // ****************************************
    // always-on clocks
    // ****************************************
    if (active[rcc_pkg::LVL_SYSTEM]) begin
      st_d.slow_src = rcc_pkg::SLOW_SRC_LS_CRYSTAL;
      st_d.fast_src = rcc_pkg::FAST_SRC_RESET;
    end else if (wr && i_paddr == rcc_pkg::ADDR_AON_CLK_CONF) begin
      if (i_pwdata[rcc_pkg::SLOW_SRC_LSB +: 2] != 2'h3) begin
        st_d.slow_src = rcc_pkg::rcc_slow_src_type'(i_pwdata[rcc_pkg::SLOW_SRC_LSB +: 2]);
      end
      st_d.fast_src = i_pwdata[rcc_pkg::FAST_SRC_BIT];
    end
    // half of the 256 divide per output phase
    if (rise[rcc_pkg::CLK_FAST_OSC]) begin
      st_d.div256_cnt = st_q.div256_cnt + rcc_pkg::DIV256_W'(1);
      if (st_q.div256_cnt == '1) begin
        st_d.fast_div256 = ~st_q.fast_div256; // see (RULE10)
      end
    end
    if (rise[rcc_pkg::CLK_CRYSTAL]) begin
      st_d.xtal_div2 = ~st_q.xtal_div2; // see (RULE12)
    end
    case (st_q.slow_src)
      rcc_pkg::SLOW_SRC_SLOW_OSC:  st_d.slow_clk = live[rcc_pkg::CLK_SLOW_OSC];   // see (RULE10)
      rcc_pkg::SLOW_SRC_FAST_DIV:  st_d.slow_clk = st_q.fast_div256;              // see (RULE10)
      default:                     st_d.slow_clk = live[rcc_pkg::CLK_LS_CRYSTAL]; // see (RULE10)
    endcase
    st_d.fast_clk = st_q.fast_src ? live[rcc_pkg::CLK_FAST_OSC] : st_q.xtal_div2; // see (RULE12)
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st_q          <= '0;
      st_q.hold     <= {NL{CNT_W'(RESET_HOLD_CYCLES)}};
      st_q.core_src <= rcc_pkg::CORE_SRC_CRYSTAL;
      st_q.core_div <= rcc_pkg::CORE_DIV_RESET;
      st_q.slow_src <= rcc_pkg::SLOW_SRC_LS_CRYSTAL;
      st_q.fast_src <= rcc_pkg::FAST_SRC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_prdata                        = st_q.prdata;
  assign o_pready                        = st_q.pready;
  assign o_pslverr                       = st_q.pslverr;
  assign o_first_processor_core_reset_n  = st_q.rst_n[rcc_pkg::LVL_FIRST];
  assign o_second_processor_core_reset_n = st_q.rst_n[rcc_pkg::LVL_SECOND];
  assign o_digital_core_reset_n          = st_q.rst_n[rcc_pkg::LVL_CORE];
  assign o_system_reset_n                = st_q.rst_n[rcc_pkg::LVL_SYSTEM];
  assign o_chip_reset_n                  = st_q.rst_n[rcc_pkg::LVL_CHIP];
  assign o_always_on_reset_n             = st_q.aon_rst_n;
  assign o_secure_reg_reset_n            = st_q.secure_rst_n;
  // slow clock feeds the always-on counter, watchdog and low-power controller
  assign o_core_clock                    = st_q.core_clk;
  assign o_slow_aon_clock                = st_q.slow_clk; // see (RULE11)
  assign o_fast_aon_clock                = st_q.fast_clk;
  assign o_main_crystal_blocked          = st_q.blocked;

endmodule : rcc_top

/* test/rcc_top_checker.sv */
// concurrent checks on the reset and clock control ports
`timescale 1ns/1ps
module rcc_top_checker #(
  parameter int RESET_HOLD_CYCLES = 16
) (
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic [11:0] i_paddr,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        i_hw_chip_reset_req,
  input wire logic        o_first_processor_core_reset_n,
  input wire logic        o_second_processor_core_reset_n,
  input wire logic        o_digital_core_reset_n,
  input wire logic        o_system_reset_n,
  input wire logic        o_chip_reset_n,
  input wire logic        o_always_on_reset_n,
  input wire logic        o_secure_reg_reset_n,
  input wire logic        o_main_crystal_blocked
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // cycles the second core has been held, saturating so it never wraps
  int low_cnt_q;
  int low_cnt_d;
  always_comb low_cnt_d = o_second_processor_core_reset_n ? 0 : low_cnt_q + (low_cnt_q < 1000);
  always_ff @(posedge i_clock) begin
    if (!i_resetn) low_cnt_q <= 0;
    else low_cnt_q <= low_cnt_d;
  end

  nest_core_a: assert property (!o_digital_core_reset_n |->
    !o_first_processor_core_reset_n && !o_second_processor_core_reset_n)
    else $error("core reset without both processor resets");
  nest_system_a: assert property (!o_system_reset_n |-> !o_digital_core_reset_n)
    else $error("system reset without core reset");
  nest_chip_a: assert property (!o_chip_reset_n |-> !o_system_reset_n)
    else $error("chip reset without system reset");
  secure_follow_a: assert property (o_secure_reg_reset_n == o_first_processor_core_reset_n)
    else $error("secure reset differs from first core reset");
  aon_follow_a: assert property (o_always_on_reset_n == o_system_reset_n)
    else $error("always-on reset differs from system reset");
  sw_second_processor_core_a: assert property (i_psel && i_penable && o_pready && i_pwrite &&
    i_paddr == rcc_pkg::ADDR_SW_RESET && i_pwdata[1] |-> ##2 !o_second_processor_core_reset_n)
    else $error("software request missed second core");
  hw_chip_a: assert property ($rose(i_hw_chip_reset_req) |-> ##[2:6] !o_chip_reset_n)
    else $error("hardware chip request not taken");
  access_one_a: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("access phase not exactly one cycle");
  idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside access");
  hold_min_a: assert property ($rose(o_second_processor_core_reset_n) |->
    low_cnt_q >= RESET_HOLD_CYCLES - 1)
    else $error("core reset released too early");
  block_keep_a: assert property ($fell(o_main_crystal_blocked) |-> ##[0:3] !o_chip_reset_n)
    else $error("crystal unblocked without chip reset");
endmodule : rcc_top_checker

bind rcc_top rcc_top_checker #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) chk_u (
  .i_clock, .i_resetn, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata, .o_prdata,
  .o_pready, .i_hw_chip_reset_req, .o_first_processor_core_reset_n,
  .o_second_processor_core_reset_n, .o_digital_core_reset_n, .o_system_reset_n,
  .o_chip_reset_n, .o_always_on_reset_n, .o_secure_reg_reset_n, .o_main_crystal_blocked
);

/* test/tb_rcc_top.sv */
// self-checking bench for the reset and clock control block
`timescale 1ns/1ps
module tb_rcc_top;
  // hold long enough that a read and two writes land while a level is active
  localparam int          HOLD   = 12;
  localparam logic [31:0] TD [8] = '{32'h0000_0010, 32'h0000_0001, 32'h0000_0012, 32'h0000_0000,
                                     32'h0000_0001, 32'h0000_0000, 32'h0000_0010, 32'h0000_0002};
  localparam int          TS [8] = '{0, 0, 0, 1, 1, 2, 2, 1};
  localparam int          TE [8] = '{200, 533, 400, 100, 160, 200, 533, 2};
  logic        i_clock, i_resetn, i_psel, i_penable, i_pwrite, err;
  logic [11:0] i_paddr, a;
  logic [31:0] i_pwdata, o_prdata, rd, d, core_q, aon_q;
  logic        o_pready, o_pslverr;
  logic [4:0]  hw_req;
  logic        i_main_crystal_clock, i_fast_osc_clock, i_slow_osc_clock;
  logic        i_low_speed_crystal_clock, i_pll_clock;
  logic [6:0]  rst_v;
  logic [3:0]  clk_v, clk_p;
  int          err_count, total_checks, seed, ph, gl, n, c;

  rcc_top #(.RESET_HOLD_CYCLES(HOLD)) dut_u (
    .i_clock, .i_resetn, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_hw_first_core_reset_req(hw_req[0]),
    .i_hw_second_core_reset_req(hw_req[1]), .i_hw_core_reset_req(hw_req[2]),
    .i_hw_system_reset_req(hw_req[3]), .i_hw_chip_reset_req(hw_req[4]),
    .i_main_crystal_clock, .i_fast_osc_clock,
    .i_slow_osc_clock, .i_low_speed_crystal_clock, .i_pll_clock,
    .o_chip_reset_n(rst_v[6]), .o_system_reset_n(rst_v[5]), .o_digital_core_reset_n(rst_v[4]),
    .o_second_processor_core_reset_n(rst_v[3]), .o_first_processor_core_reset_n(rst_v[2]),
    .o_always_on_reset_n(rst_v[1]), .o_secure_reg_reset_n(rst_v[0]),
    .o_core_clock(clk_v[0]), .o_slow_aon_clock(clk_v[1]), .o_fast_aon_clock(clk_v[2]),
    .o_main_crystal_blocked(clk_v[3])
  );

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // source clocks well below half the sampling rate; gl injects a one-sample crystal phase
  always @(posedge i_clock) begin
    ph <= ph + 1;
    if (gl != 0) begin
      i_main_crystal_clock <= ~i_main_crystal_clock;
      gl <= gl - 1;
    end else if (ph % 4 == 3) i_main_crystal_clock <= ~i_main_crystal_clock;
    if (ph % 3 == 2) i_fast_osc_clock <= ~i_fast_osc_clock;
    if (ph % 10 == 9) i_slow_osc_clock <= ~i_slow_osc_clock;
    if (ph % 16 == 15) i_low_speed_crystal_clock <= ~i_low_speed_crystal_clock;
    if (ph % 2 == 1) i_pll_clock <= ~i_pll_clock;
  end
  always @(posedge i_clock) clk_p <= clk_v;

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out;
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= ad;
    i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // one idle edge, so the next call never re-drives psel in this time step
    @(posedge i_clock);
  endtask : apb

  task automatic wait_release;
    n = 0;
    repeat (3) @(posedge i_clock);
    while (rst_v !== 7'h7f && n < 200) begin
      @(posedge i_clock);
      n++;
    end
    check("all_released", rst_v, 7'h7f);
  endtask : wait_release

  function automatic logic [4:0] scope(input int lvl);
    case (lvl)
      0: return 5'h01;
      1: return 5'h02;
      2: return 5'h07;
      3: return 5'h0f;
      default: return 5'h1f;
    endcase
  endfunction : scope

  function automatic logic [6:0] rst_exp(input logic [4:0] m);
    return ~{m[4], m[3], m[2], m[1], m[0], m[3], m[0]};
  endfunction : rst_exp

  // an unusable source code keeps the previous source
  function automatic logic [31:0] conf_exp(input logic core, input logic [31:0] old, wr);
    logic [1:0] s;
    s = (wr[1:0] == 2'h3) ? old[1:0] : wr[1:0];
    return core ? {20'h0_0000, wr[11:4], 2'h0, s} : {27'h000_0000, wr[4], 2'h0, s};
  endfunction : conf_exp

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {i_resetn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, hw_req} = '0;
    {i_main_crystal_clock, i_fast_osc_clock, i_slow_osc_clock} = 3'h0;
    {i_low_speed_crystal_clock, i_pll_clock} = 2'h0;
    {ph, gl, err_count, total_checks} = '0;
    seed = 59;
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    wait_release;
    apb(0, rcc_pkg::ADDR_CORE_CLK_CONF, 0);
    check("core_conf_reset", rd, 32'h0000_0010);
    for (int i = 0; i < 8; i++) begin
      apb(1, (i < 3) ? rcc_pkg::ADDR_CORE_CLK_CONF : rcc_pkg::ADDR_AON_CLK_CONF, TD[i]);
      repeat (20) @(posedge i_clock);
      c = 0;
      repeat (3200) begin
        @(posedge i_clock);
        if (clk_v[TS[i]] === 1'b1 && clk_p[TS[i]] === 1'b0) c++;
      end
      check("clock_rate", (c >= TE[i] - 1 && c <= TE[i] + 1), 1);
    end
    core_q = TD[2];
    aon_q = TD[7];
    for (int i = 0; i < 20; i++) begin
      a = ($random(seed) & 1) ? rcc_pkg::ADDR_CORE_CLK_CONF : rcc_pkg::ADDR_AON_CLK_CONF;
      d = $random(seed);
      if (i == 0) d[1:0] = 2'h3;
      apb(1, a, d);
      apb(0, a, 0);
      if (a == rcc_pkg::ADDR_CORE_CLK_CONF) core_q = conf_exp(1, core_q, d);
      else aon_q = conf_exp(0, aon_q, d);
      check("conf_readback", rd, (a == rcc_pkg::ADDR_CORE_CLK_CONF) ? core_q : aon_q);
    end
    apb(1, 12'h010, $random(seed));
    check("unmapped_err", err, 1);
    apb(1, rcc_pkg::ADDR_STATUS, 32'hffff_ffff);
    apb(0, rcc_pkg::ADDR_STATUS, 0);
    check("status_idle", rd, 0);
    check("status_err", err, 0);
    for (int lvl = 0; lvl < 5; lvl++) begin
      apb(1, rcc_pkg::ADDR_CORE_CLK_CONF, 32'h0000_0052);
      apb(1, rcc_pkg::ADDR_AON_CLK_CONF, 32'h0000_0011);
      apb(1, rcc_pkg::ADDR_SW_RESET, 32'h0000_0001 << lvl);
      apb(0, rcc_pkg::ADDR_SW_RESET, 0);
      check("levels_active", rd, {27'h000_0000, scope(lvl)});
      check("reset_pattern", rst_v, rst_exp(scope(lvl)));
      apb(1, rcc_pkg::ADDR_CORE_CLK_CONF, 32'h0000_0031);
      apb(1, rcc_pkg::ADDR_AON_CLK_CONF, 32'h0000_0002);
      wait_release;
      apb(0, rcc_pkg::ADDR_CORE_CLK_CONF, 0);
      check("core_conf_after", rd, scope(lvl)[0] ? 32'h0000_0010 : 32'h0000_0031);
      apb(0, rcc_pkg::ADDR_AON_CLK_CONF, 0);
      check("aon_conf_after", rd, scope(lvl)[3] ? 32'h0000_0000 : 32'h0000_0002);
    end
    for (int lvl = 0; lvl < 5; lvl++) begin
      hw_req <= 5'h01 << lvl;
      @(posedge i_clock);
      hw_req <= 5'h00;
      repeat (6) @(posedge i_clock);
      check("hw_pattern", rst_v, rst_exp(scope(lvl)));
      wait_release;
    end
    gl <= 2;
    repeat (10) @(posedge i_clock);
    check("crystal_blocked", clk_v[3], 1);
    c = 0;
    repeat (240) begin
      @(posedge i_clock);
      if (clk_v[0] === 1'b1 && clk_p[0] === 1'b0) c++;
    end
    check("blocked_core_clock", c, 0);
    apb(1, rcc_pkg::ADDR_SW_RESET, 32'h0000_0010);
    wait_release;
    check("crystal_unblocked", clk_v[3], 0);
    close_out;
  end

  initial begin
    repeat (40000) @(posedge i_clock);
    err_count++;
    close_out;
  end
endmodule : tb_rcc_top
